// ---- logic/ppc_top.sv ----
// printer port control: registers, pin drive, mode logic and byte path
`timescale 1ns/10ps
`default_nettype none
module ppc_top
    import ppc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [15:0] reg_app,
    input  wire logic [3:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        bo_valid,
    output logic             bo_ready,
    input  wire logic [7:0]  bo_data,
    output logic             bi_valid,
    input  wire logic        bi_ready,
    output logic      [7:0]  bi_data,
    input  wire logic [7:0]  port_data_lines_in,
    output logic      [7:0]  port_data_lines_out,
    output logic      [7:0]  port_data_lines_oe,
    output logic             latch_pulse_pin_n,
    output logic             line_feed_auto_pin_n,
    output logic             printer_setup_pin_n,
    output logic             printer_choose_pin_n,
    input  wire logic        busy_pin,
    input  wire logic        handoff_pulse_n,
    input  wire logic        sheet_out_flag,
    input  wire logic        online_flag,
    input  wire logic        error_flag_n
);

    typedef struct packed {
        logic [7:0]      ctrl;
        logic [7:0]      data;
        logic [2:0]      mode;
        logic [7:0]      vend;
        logic [7:0]      rdata;
        logic            rvalid;
        logic [1:0][7:0] mem;
        logic [1:0]      cnt;
        logic            rp;
        ppc_state_e      st;
        logic [7:0]      ob;
        logic [3:0]      div;
        logic            ack_q;
        logic [3:0]      nib_hi;
        logic            nib_half;
        logic            bi_valid;
        logic [7:0]      bi_data;
    } ppc_state_s;
    ppc_state_s s_r;
    ppc_state_s s_nxt;
    logic       app_port;
    logic       app_vend;
    logic       hold;
    logic       fifo_mode;
    logic       compat;
    logic       loop;
    logic [2:0] clk_sel;
    logic [3:0] div_mask;
    logic       tick;
    logic       bi_free;
    logic       pop_loop;
    logic       pop_fifo;
    logic       push;
    logic       ack_fall;
    logic [3:0] nib_now;
    // access decode and mode shorthands
    assign app_port  = (reg_app == APP_PORT);
    assign app_vend  = (reg_app == APP_VEND);
    assign hold      = s_r.vend[VND_HOLD];
    assign loop      = s_r.vend[VND_LOOP];
    assign fifo_mode = (s_r.mode == MODE_FIFO);
    assign compat    = (s_r.mode == MODE_COMPAT);
    assign ack_fall  = s_r.ack_q & ~handoff_pulse_n;
    assign nib_now   = {busy_pin, sheet_out_flag, online_flag, error_flag_n};
    // port clock: one tick every 2^code cycles; codes above 4 act as 4
    assign clk_sel  = (s_r.vend[VND_CLK_LSB +: 3] > CLK_SEL_MAX) ?
                      CLK_SEL_MAX : s_r.vend[VND_CLK_LSB +: 3];
    assign div_mask = 4'((5'h01 << clk_sel) - 5'h01);
    assign tick     = ((s_r.div & div_mask) == 4'h0);
    // buffer handshakes; a flush or hold stalls the source instead of
    // dropping a byte that is mid-transfer
    assign bi_free  = ~s_r.bi_valid | bi_ready;
    assign bo_ready = (s_r.cnt != BUF_DEPTH) & ~hold & ~s_r.vend[VND_BOFL];
    assign push     = bo_valid & bo_ready;
    assign pop_loop = loop & (s_r.cnt != 2'h0) & bi_free &
                      ~s_r.vend[VND_BIFL];
    assign pop_fifo = ~loop & fifo_mode & (s_r.st == ST_IDLE) &
                      (s_r.cnt != 2'h0) & tick;
    // next state of all registers
    always_comb begin
        s_nxt        = s_r;
        s_nxt.rvalid = 1'b0;
        s_nxt.ack_q  = handoff_pulse_n;
        s_nxt.div    = s_r.div + 4'h1;
        // register writes; the vendor register survives the port hold
        if (reg_wr && app_vend && reg_addr == ADDR_VEND) begin
            s_nxt.vend = reg_wdata & VEND_MASK;
        end
        if (reg_wr && app_port && !hold) begin
            unique case (reg_addr)
                ADDR_DATA: s_nxt.data = reg_wdata;
                ADDR_CTRL: s_nxt.ctrl = reg_wdata & CTRL_MASK;
                ADDR_MODE: s_nxt.mode = reg_wdata[MODE_LSB +: 3];
                default: ;
            endcase
        end
        // register reads, answered one cycle later; misses read zero
        if (reg_rd) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = 8'h00;
            if (app_vend && reg_addr == ADDR_VEND) begin
                s_nxt.rdata = s_r.vend;
            end
            if (app_port) begin
                unique case (reg_addr)
                    ADDR_DATA: s_nxt.rdata = port_data_lines_in;
                    ADDR_STAT: s_nxt.rdata = {~busy_pin, handoff_pulse_n,
                                   sheet_out_flag, online_flag,
                                   error_flag_n, 3'h0};
                    ADDR_CTRL: s_nxt.rdata = s_r.ctrl;
                    ADDR_MODE: s_nxt.rdata = {s_r.mode, 5'h00};
                    default: ;
                endcase
            end
        end

        // two-entry bulk-out buffer
        if (push) begin
            s_nxt.mem[s_r.rp ^ (s_r.cnt != 2'h0)] = bo_data;
        end
        if (pop_loop || pop_fifo) begin
            s_nxt.rp = ~s_r.rp;
        end
        s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop_loop | pop_fifo};
        // bulk-in output stage, fed by loopback or nibble capture
        if (bi_ready) begin
            s_nxt.bi_valid = 1'b0;
        end
        if (pop_loop) begin
            s_nxt.bi_valid = 1'b1;
            s_nxt.bi_data  = s_r.mem[s_r.rp];
        end else if (!loop && s_r.mode == MODE_NIBBLE && ack_fall) begin
            // high nibble first; a low nibble finding the output full is dropped and the high nibble kept
            if (!s_r.nib_half) begin
                s_nxt.nib_hi   = nib_now;
                s_nxt.nib_half = 1'b1;
            end else if (bi_free) begin
                s_nxt.bi_valid = 1'b1;
                s_nxt.bi_data  = {s_r.nib_hi, nib_now};
                s_nxt.nib_half = 1'b0;
            end
        end
        if (s_r.mode != MODE_NIBBLE) begin
            s_nxt.nib_half = 1'b0;
        end
        // automatic output handshake paced by the port clock
        unique case (s_r.st)
            ST_IDLE: begin
                if (pop_fifo) begin
                    s_nxt.ob = s_r.mem[s_r.rp];
                    s_nxt.st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (tick && !busy_pin) begin
                    s_nxt.st = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (tick) begin
                    s_nxt.st = ST_ACK;
                end
            end
            ST_ACK: begin
                if (ack_fall) begin
                    s_nxt.st = ST_REL;
                end
            end
            ST_REL: begin
                if (handoff_pulse_n) begin
                    s_nxt.st = ST_IDLE;
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
        // flushes empty their fifo; the hold resets all port logic
        if (s_r.vend[VND_BOFL]) begin
            s_nxt.cnt = 2'h0;
            s_nxt.rp  = 1'b0;
        end
        if (s_r.vend[VND_BIFL]) begin
            s_nxt.bi_valid = 1'b0;
            s_nxt.nib_half = 1'b0;
        end
        if (hold) begin
            s_nxt.ctrl     = CTRL_RST;
            s_nxt.data     = DATA_RST;
            s_nxt.mode     = MODE_RST;
            s_nxt.cnt      = 2'h0;
            s_nxt.rp       = 1'b0;
            s_nxt.st       = ST_IDLE;
            s_nxt.div      = 4'h0;
            s_nxt.nib_half = 1'b0;
            s_nxt.bi_valid = 1'b0;
        end
    end
    // single state register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_r      <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.data <= DATA_RST;
            s_r.mode <= MODE_RST;
            s_r.vend <= VEND_RST;
            s_r.st   <= ST_IDLE;
            s_r.ack_q <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // pin drive; fifo mode owns the strobe and data lines
    assign latch_pulse_pin_n    = fifo_mode ? (s_r.st != ST_PULSE) :
                                  ~s_r.ctrl[CTL_STROBE];
    assign line_feed_auto_pin_n = ~s_r.ctrl[CTL_LINE_FEED_AUTO_BIT];
    assign printer_setup_pin_n  = s_r.ctrl[CTL_INIT];
    assign printer_choose_pin_n = ~s_r.ctrl[CTL_CHOOSE];
    assign port_data_lines_out  = fifo_mode ? s_r.ob : s_r.data;
    assign port_data_lines_oe   = (compat || fifo_mode || !s_r.ctrl[CTL_DIR])
                                  ? 8'hFF : 8'h00;
    assign reg_rdata  = s_r.rdata;
    assign reg_rvalid = s_r.rvalid;
    assign bi_valid   = s_r.bi_valid;
    assign bi_data    = s_r.bi_data;

    // checks on the design's own outputs
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_ctrl_wr;
        reg_wr && app_port && reg_addr == ADDR_CTRL && !hold && !fifo_mode;
    endsequence
    sequence s_strobe_low;
        s_r.st == ST_PULSE && !latch_pulse_pin_n;
    endsequence

    property p_strobe;
        s_ctrl_wr |=> latch_pulse_pin_n == !$past(reg_wdata[CTL_STROBE]);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe pin wrong");
    property p_line_feed_auto_bit;
        s_ctrl_wr |=> line_feed_auto_pin_n == !$past(reg_wdata[CTL_LINE_FEED_AUTO_BIT]);
    endproperty
    a_line_feed_auto_bit: assert property (p_line_feed_auto_bit) else $error("line_feed_auto_bit pin");
    property p_init;
        s_ctrl_wr |=> printer_setup_pin_n == $past(reg_wdata[CTL_INIT]);
    endproperty
    a_init: assert property (p_init) else $error("init pin wrong");
    property p_choose;
        s_ctrl_wr |=> printer_choose_pin_n == !$past(reg_wdata[CTL_CHOOSE]);
    endproperty
    a_choose: assert property (p_choose) else $error("select pin");
    property p_dir_in;
        s_r.mode == MODE_NIBBLE && s_r.ctrl[CTL_DIR]
            |-> port_data_lines_oe == 8'h00;
    endproperty
    a_dir_in: assert property (p_dir_in) else $error("dir ignored");
    property p_compat_out;
        compat |-> port_data_lines_oe == 8'hFF;
    endproperty
    a_compat_out: assert property (p_compat_out) else $error("oe off");
    property p_ctrl_unused;
        reg_rd && app_port && reg_addr == ADDR_CTRL
            |=> reg_rvalid && (reg_rdata & ~CTRL_MASK) == 8'h00;
    endproperty
    a_ctrl_unused: assert property (p_ctrl_unused) else $error("bits");
    property p_mode_rsvd;
        reg_rd && app_port && reg_addr == ADDR_MODE
            |=> reg_rdata[4:0] == 5'h00;
    endproperty
    a_mode_rsvd: assert property (p_mode_rsvd) else $error("reserved");
    property p_busy_inv;
        reg_rd && app_port && reg_addr == ADDR_STAT
            |=> reg_rdata[7] == !$past(busy_pin);
    endproperty
    a_busy_inv: assert property (p_busy_inv) else $error("busy bit");
    property p_app_miss;
        reg_rd && !app_port && !app_vend |=> reg_rdata == 8'h00;
    endproperty
    a_app_miss: assert property (p_app_miss) else $error("app decode");
    property p_hold;
        // ready drops with the hold itself; the pins follow one cycle on
        hold |-> !bo_ready ##1 (latch_pulse_pin_n && s_r.mode == MODE_RST);
    endproperty
    a_hold: assert property (p_hold) else $error("hold ignored");
    property p_fifo_strobe;
        fifo_mode && s_r.st == ST_SETUP && tick && !busy_pin && !hold
            |=> s_strobe_low;
    endproperty
    a_fifo_strobe: assert property (p_fifo_strobe) else $error("no strobe");
    property p_loop;
        pop_loop && !hold |=> bi_valid && bi_data == $past(s_r.mem[s_r.rp]);
    endproperty
    a_loop: assert property (p_loop) else $error("loop byte lost");

endmodule
`default_nettype wire

// ---- logic/ppc_pkg.sv ----
// constants, register map and state encoding of the printer port control
package ppc_pkg;
    // register offsets within an application number
    localparam logic [3:0]  ADDR_DATA    = 4'h0;
    localparam logic [3:0]  ADDR_STAT    = 4'h1;
    localparam logic [3:0]  ADDR_CTRL    = 4'h2;
    localparam logic [3:0]  ADDR_VEND    = 4'h4;
    localparam logic [3:0]  ADDR_MODE    = 4'hA;
    localparam logic [15:0] APP_PORT     = 16'h0100;
    localparam logic [15:0] APP_VEND     = 16'h0000;
    // printer control fields
    localparam int          CTL_STROBE   = 0;
    localparam int          CTL_LINE_FEED_AUTO_BIT   = 1;
    localparam int          CTL_INIT     = 2;
    localparam int          CTL_CHOOSE   = 3;
    localparam int          CTL_DIR      = 5;
    localparam logic [7:0]  CTRL_MASK    = 8'h2F;
    localparam logic [7:0]  CTRL_RST     = 8'h04;
    localparam logic [7:0]  DATA_RST     = 8'h00;
    // port mode field
    localparam int          MODE_LSB     = 5;
    localparam logic [2:0]  MODE_COMPAT  = 3'h0;
    localparam logic [2:0]  MODE_NIBBLE  = 3'h1;
    localparam logic [2:0]  MODE_FIFO    = 3'h2;
    localparam logic [2:0]  MODE_RST     = MODE_NIBBLE;
    // port vendor fields
    localparam int          VND_LOOP     = 0;
    localparam int          VND_BOFL     = 2;
    localparam int          VND_BIFL     = 3;
    localparam int          VND_CLK_LSB  = 4;
    localparam int          VND_HOLD     = 7;
    localparam logic [7:0]  VEND_MASK    = 8'hFD;
    localparam logic [7:0]  VEND_RST     = 8'h00;
    localparam logic [2:0]  CLK_SEL_MAX  = 3'h4;
    localparam logic [1:0]  BUF_DEPTH    = 2'h2;

    // automatic output handshake, gray along the usual path except the return from ST_REL to ST_IDLE
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_SETUP = 3'h1,
        ST_PULSE = 3'h3,
        ST_ACK   = 3'h2,
        ST_REL   = 3'h6
    } ppc_state_e;
endpackage

// ---- sim/ppc_printer.sv ----
// behavioural printer: latches strobed bytes, acknowledges, sends nibbles
`timescale 1ns/10ps
`default_nettype none
module ppc_printer (
    input  wire logic       ref_clk,
    input  wire logic       latch_pulse_pin_n,
    input  wire logic [7:0] pd,
    input  wire logic [7:0] ack_dly,
    output var  logic       busy_pin,
    output var  logic       handoff_pulse_n,
    output var  logic       sheet_out_flag,
    output var  logic       online_flag,
    output var  logic       error_flag_n,
    output var  logic [7:0] got_byte,
    output var  logic [7:0] got_count,
    output var  logic [7:0] strobe_w
);
    logic       prev_n    = 1'b1;
    logic [7:0] wcnt      = 8'h00;
    logic [8:0] ack_cnt   = 9'h000;
    logic       busy_r    = 1'b0;
    logic       ack_r_n   = 1'b1;
    logic [3:0] nib_v     = 4'h3;
    logic       nib_ack_n = 1'b1;
    logic [7:0] byte_r    = 8'h00;
    logic [7:0] count_r   = 8'h00;
    logic [7:0] width_r   = 8'h00;

    // idle lines: ready, paper present, online, no error; the strobe
    // logic and the nibble task meet here so each line has one driver
    assign {busy_pin, sheet_out_flag, online_flag, error_flag_n} =
        {busy_r | nib_v[3], nib_v[2:0]};
    assign handoff_pulse_n = ack_r_n & nib_ack_n;
    assign got_byte        = byte_r;
    assign got_count       = count_r;
    assign strobe_w        = width_r;

    // latch on the falling strobe, acknowledge after a settable delay
    always @(posedge ref_clk) begin
        prev_n <= latch_pulse_pin_n;
        wcnt <= latch_pulse_pin_n ? 8'h00 : wcnt + 8'h01;
        if (prev_n && !latch_pulse_pin_n) begin
            byte_r <= pd;
            busy_r <= 1'b1;
        end
        if (!prev_n && latch_pulse_pin_n) begin
            count_r <= count_r + 8'h01;
            width_r <= wcnt;
            ack_cnt <= {1'b0, ack_dly} + 9'h004;
        end else if (ack_cnt != 9'h000) begin
            ack_cnt <= ack_cnt - 9'h001;
            if (ack_cnt == 9'h003) begin
                ack_r_n <= 1'b0;
            end
            if (ack_cnt == 9'h001) begin
                ack_r_n <= 1'b1;
                busy_r <= 1'b0;
            end
        end
    end

    // one reverse nibble on the status lines, framed by an ack pulse
    task automatic send_nibble(input logic [3:0] v);
        @(posedge ref_clk);
        #1;
        nib_v = v;
        repeat (2) @(posedge ref_clk);
        #1;
        nib_ack_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        nib_ack_n = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        nib_v = 4'h3;
    endtask
endmodule
`default_nettype wire

// ---- sim/printer_port_control_tb.sv ----
// self-checking bench for the printer port control
`timescale 1ns/10ps
`default_nettype none
module printer_port_control_tb;
    import ppc_pkg::*;
    logic        ref_clk, resetn, reg_wr, reg_rd, reg_rvalid;
    logic [15:0] reg_app;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, bo_data, bi_data, prn_drive, pd;
    logic        bo_valid, bo_ready, bi_valid, bi_ready, busy_pin;
    logic [7:0]  port_data_lines_in, port_data_lines_out, port_data_lines_oe;
    logic        latch_pulse_pin_n, line_feed_auto_pin_n, printer_setup_pin_n;
    logic        printer_choose_pin_n, handoff_pulse_n, sheet_out_flag;
    logic        online_flag, error_flag_n;
    logic [7:0]  got_byte, got_count, strobe_w, ack_dly, pins, w0, c;
    int          failures = 0, check_count = 0, cycles = 0;
    logic [7:0]  cv[4] = '{8'h05, 8'h06, 8'h00, 8'h0C};
    logic [7:0]  pv[4] = '{8'h07, 8'h0B, 8'h0D, 8'h0E};

    // wire level: whoever drives each data line sets it
    assign pd = (port_data_lines_oe & port_data_lines_out)
              | (~port_data_lines_oe & prn_drive);
    assign port_data_lines_in = pd;
    assign pins = {4'h0, latch_pulse_pin_n, line_feed_auto_pin_n,
                   printer_setup_pin_n, printer_choose_pin_n};

    ppc_top i_ppc_top (.ref_clk, .resetn, .reg_app, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .bo_valid, .bo_ready,
        .bo_data, .bi_valid, .bi_ready, .bi_data, .port_data_lines_in,
        .port_data_lines_out, .port_data_lines_oe, .latch_pulse_pin_n,
        .line_feed_auto_pin_n, .printer_setup_pin_n, .printer_choose_pin_n,
        .busy_pin, .handoff_pulse_n, .sheet_out_flag, .online_flag,
        .error_flag_n);

    ppc_printer i_ppc_printer (.ref_clk, .latch_pulse_pin_n, .pd, .ack_dly,
        .busy_pin, .handoff_pulse_n, .sheet_out_flag, .online_flag,
        .error_flag_n, .got_byte, .got_count, .strobe_w);

    // 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // cut a hang short well past the expected run length
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check_val(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] app, input logic [3:0] a,
                      input logic [7:0] d);
        idle(1);
        reg_app = app;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        idle(1);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] app, input logic [3:0] a,
                      input logic [7:0] exp);
        idle(1);
        reg_app = app;
        reg_addr = a;
        reg_rd = 1'b1;
        idle(1);
        reg_rd = 1'b0;
        check_val({7'h00, reg_rvalid}, 8'h01);
        check_val(reg_rdata, exp);
    endtask

    // bulk-out beat held until the design shows ready
    task automatic push(input logic [7:0] d);
        int n;
        idle(1);
        bo_data = d;
        bo_valid = 1'b1;
        n = 0;
        while (bo_ready !== 1'b1 && n < 50) begin
            idle(1);
            n++;
        end
        check_val({7'h00, bo_ready}, 8'h01);
        idle(1);
        bo_valid = 1'b0;
    endtask

    task automatic pop(input logic [7:0] exp);
        int n;
        n = 0;
        while (bi_valid !== 1'b1 && n < 200) begin
            idle(1);
            n++;
        end
        check_val({7'h00, bi_valid}, 8'h01);
        check_val(bi_data, exp);
        bi_ready = 1'b1;
        idle(1);
        bi_ready = 1'b0;
    endtask

    // wait for the printer to latch one more byte, let its ack finish
    task automatic wait_byte(input logic [7:0] old, input logic [7:0] exp);
        int n;
        n = 0;
        while (got_count === old && n < 600) begin
            idle(1);
            n++;
        end
        check_val(got_count, old + 8'h01);
        check_val(got_byte, exp);
        idle(40);
    endtask

    initial begin
        {resetn, reg_wr, reg_rd, bo_valid, bi_ready} = 5'h00;
        {reg_app, reg_addr, reg_wdata, bo_data} = 36'h0;
        prn_drive = 8'h00;
        ack_dly = 8'h00;
        idle(2);
        resetn = 1'b1;
        rd(APP_PORT, ADDR_CTRL, CTRL_RST);
        rd(APP_PORT, ADDR_MODE, 8'h20);
        rd(APP_PORT, ADDR_DATA, DATA_RST);
        rd(APP_VEND, ADDR_VEND, VEND_RST);
        check_val(pins, 8'h0F);
        check_val(port_data_lines_oe, 8'hFF);
        wr(APP_VEND, ADDR_VEND, 8'hFF);
        rd(APP_VEND, ADDR_VEND, 8'hFD);
        wr(APP_VEND, ADDR_VEND, 8'h00);
        wr(APP_VEND, ADDR_CTRL, 8'h01);
        idle(1);
        check_val(pins, 8'h0F);
        rd(APP_PORT, ADDR_VEND, 8'h00);
        rd(16'h0200, ADDR_CTRL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(APP_PORT, ADDR_CTRL, cv[i]);
            idle(1);
            check_val(pins, pv[i]);
        end
        // strobe bit left clear so the printer stays idle for the status read
        wr(APP_PORT, ADDR_CTRL, 8'hFE);
        rd(APP_PORT, ADDR_CTRL, 8'h2E);
        check_val(port_data_lines_oe, 8'h00);
        wr(APP_PORT, ADDR_MODE, 8'h1F);
        rd(APP_PORT, ADDR_MODE, 8'h00);
        check_val(port_data_lines_oe, 8'hFF);
        wr(APP_PORT, ADDR_DATA, 8'hA5);
        wr(APP_PORT, ADDR_CTRL, 8'h04);
        rd(APP_PORT, ADDR_DATA, 8'hA5);
        // software-paced transfer: status first, then the strobe
        rd(APP_PORT, ADDR_STAT, 8'hD8);
        c = got_count;
        wr(APP_PORT, ADDR_CTRL, 8'h05);
        wr(APP_PORT, ADDR_CTRL, 8'h04);
        wait_byte(c, 8'hA5);
        wr(APP_PORT, ADDR_MODE, 8'h20);
        wr(APP_PORT, ADDR_CTRL, 8'h24);
        prn_drive = 8'h3C;
        rd(APP_PORT, ADDR_DATA, 8'h3C);
        wr(APP_PORT, ADDR_CTRL, 8'h04);
        i_ppc_printer.send_nibble(4'hA);
        i_ppc_printer.send_nibble(4'h5);
        pop(8'hA5);
        // loopback with the receiver stalled until the buffer refuses
        wr(APP_VEND, ADDR_VEND, 8'h01);
        push(8'h11);
        push(8'h22);
        push(8'h33);
        idle(2);
        check_val({7'h00, bo_ready}, 8'h00);
        pop(8'h11);
        pop(8'h22);
        pop(8'h33);
        wr(APP_VEND, ADDR_VEND, 8'h00);
        push(8'h44);
        push(8'h55);
        idle(1);
        check_val({7'h00, bo_ready}, 8'h00);
        wr(APP_VEND, ADDR_VEND, 8'h04);
        wr(APP_VEND, ADDR_VEND, 8'h01);
        idle(4);
        check_val({7'h00, bi_valid}, 8'h00);
        push(8'h66);
        idle(3);
        check_val({7'h00, bi_valid}, 8'h01);
        wr(APP_VEND, ADDR_VEND, 8'h09);
        idle(1);
        check_val({7'h00, bi_valid}, 8'h00);
        wr(APP_VEND, ADDR_VEND, 8'h00);
        // automatic output, fastest pacing, then a slower clock code
        wr(APP_PORT, ADDR_MODE, 8'h00);
        wr(APP_PORT, ADDR_MODE, 8'h40);
        rd(APP_PORT, ADDR_MODE, 8'h40);
        c = got_count;
        push(8'h5A);
        wait_byte(c, 8'h5A);
        w0 = strobe_w;
        wr(APP_VEND, ADDR_VEND, 8'h80);
        wr(APP_PORT, ADDR_CTRL, 8'h05);
        idle(1);
        check_val(pins, 8'h0F);
        rd(APP_PORT, ADDR_MODE, 8'h20);
        wr(APP_VEND, ADDR_VEND, 8'hA0);
        wr(APP_VEND, ADDR_VEND, 8'h20);
        ack_dly = 8'd20;
        wr(APP_PORT, ADDR_MODE, 8'h00);
        wr(APP_PORT, ADDR_MODE, 8'h40);
        c = got_count;
        push(8'hC3);
        wait_byte(c, 8'hC3);
        check_val({7'h00, strobe_w > w0}, 8'h01);
        finish_test();
    end
endmodule
`default_nettype wire
